// ==== rtl/dual_timer_counter_mode_ctrl.sv ====
// Dual 16-bit timer/counter with shared mode register, Avalon-MM slave
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
// How it works
// [RL1] Two counters, each a high and low byte forming sixteen bits.
// [RL2] Per-counter source select: bit 2 counter 0, bit 6 counter 1.
// [RL3] Internal timing advances once every six peripheral clocks.
// [RL4] External counting increments on each falling edge of own count pin.
// [RL5] Pin sampled once per machine cycle; edge is high then low sample.
// [RL6] Counter 1 gate bit 7: set means run needs gate pin high too.
// [RL7] Counter 0 gate bit 3 clear: runs on run bit alone.
// [RL8] Counter 1 mode bits 5:4: 13-bit, 16-bit, reload, halted.
// [RL9] Counter 0 mode bits 1:0 same encodings, reload from own high.
// [RL10] Counter 0 mode 11 splits into two independent 8-bit counters.
// [RL11] Enable is run bit and either gate clear or gate pin high.
// [RL12] Mode 00 counts 13 bits, flag on wrap from 1FFF to 0.
// [RL13] Mode 10 low byte wrap sets flag, reloads from high byte.
// [RL14] Split high byte counts machine cycles on counter 1 run bit and flag.
// [RL15] Mode 01 sets flag on 16-bit wrap and continues from zero.
// [RL16] Count byte writes act at once; mode changes from next count.
module dual_timer_counter_mode_ctrl #(
	parameter int DIV = `TMR_PERIPH_DIV
) (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic [11:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output var logic [31:0] AVS_READDATA_OUT,
	output var logic AVS_WAITREQUEST_OUT,
	input wire logic COUNT_PIN_ZERO_IN,
	input wire logic COUNT_PIN_ONE_IN,
	input wire logic GATE_PIN_ZERO_IN,
	input wire logic GATE_PIN_ONE_IN,
	output var logic IRQ_OUT
);
	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	if (DIV < 2 || DIV > 256) begin : g_bad_div
		$error("DIV must lie in 2..256");
	end

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
		return addr[11:2] == idx;
	endfunction

	// One counting step: {overflow, high, low}
	function automatic logic [16:0] step(input timer_pkg::tmr_mode_t m, input logic [7:0] hi,
			input logic [7:0] lo);
		logic [16:0] r;
		r = {1'b0, hi, lo};
		case (m)
			timer_pkg::MODE_PRESCALE13: begin
				r[4:0] = lo[4:0] + 5'h01; // [RL12]
				if (&lo[4:0]) begin
					r[15:8] = hi + 8'h01;
					r[16] = &hi;
				end
			end
			timer_pkg::MODE_FULL16: begin
				r = {1'b0, hi, lo} + 17'h0_0001; // [RL15]
			end
			timer_pkg::MODE_RELOAD8: begin
				if (&lo) begin
					r = {1'b1, hi, hi}; // [RL13]
				end else begin
					r[7:0] = lo + 8'h01;
				end
			end
			timer_pkg::MODE_SPLIT: begin
				r[7:0] = lo + 8'h01; // [RL10]
				r[16] = &lo;
			end
			default: begin
				r = {1'b0, hi, lo};
			end
		endcase
		return r;
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic wait_r, req;
	logic bus_wr, bus_rd;
	logic [7:0] wd;
	logic [7:0] mode_r;
	logic run0_r, run1_r;
	logic flag0_r, flag1_r;
	logic [7:0] low0_r, high0_r;
	logic [7:0] low1_r, high1_r;
	logic [1:0] stat_r, stat_nxt;
	logic [1:0] mask_r;
	logic [7:0] pre_r;
	logic tick_r;
	logic [1:0] cnt_pin;
	logic [1:0] fall;
	logic [7:0] ctrl_val;
	timer_pkg::tmr_mode_t m0, m1;
	logic split0;
	logic en0, en1;
	logic inc0, inc1, inc0h;
	logic ovf0, ovf1;
	logic [16:0] st0, st1;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	// Fixed two-cycle access keeps read data registered
	assign req = AVS_READ_IN | AVS_WRITE_IN;
	assign bus_wr = AVS_WRITE_IN & ~wait_r & AVS_BYTEENABLE_IN[0];
	assign bus_rd = AVS_READ_IN & ~wait_r;
	assign wd = AVS_WRITEDATA_IN[7:0];
	assign AVS_WAITREQUEST_OUT = wait_r;

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= ~(req & wait_r);
		end
	end

	always_comb begin
		ctrl_val = 8'h00;
		ctrl_val[`TMR_FLAG1] = flag1_r;
		ctrl_val[`TMR_RUN1] = run1_r;
		ctrl_val[`TMR_FLAG0] = flag0_r;
		ctrl_val[`TMR_RUN0] = run0_r;
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			AVS_READDATA_OUT <= 32'h0000_0000;
		end else if (req && wait_r) begin
			case (AVS_ADDRESS_IN[11:2])
				`TMR_IDX_CTRL: AVS_READDATA_OUT <= {24'h00_0000, ctrl_val};
				`TMR_IDX_MODE: AVS_READDATA_OUT <= {24'h00_0000, mode_r};
				`TMR_IDX_LOW0: AVS_READDATA_OUT <= {24'h00_0000, low0_r};
				`TMR_IDX_LOW1: AVS_READDATA_OUT <= {24'h00_0000, low1_r};
				`TMR_IDX_HIGH0: AVS_READDATA_OUT <= {24'h00_0000, high0_r};
				`TMR_IDX_HIGH1: AVS_READDATA_OUT <= {24'h00_0000, high1_r};
				`TMR_IDX_STAT: AVS_READDATA_OUT <= {30'h0000_0000, stat_r};
				`TMR_IDX_MASK: AVS_READDATA_OUT <= {30'h0000_0000, mask_r};
				default: AVS_READDATA_OUT <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			mode_r <= `TMR_MODE_RST;
			run0_r <= 1'b0;
			run1_r <= 1'b0;
			mask_r <= 2'h0;
		end else begin
			if (bus_wr && hit(AVS_ADDRESS_IN, `TMR_IDX_MODE)) begin
				mode_r <= wd; // [RL16]
			end
			if (bus_wr && hit(AVS_ADDRESS_IN, `TMR_IDX_CTRL)) begin
				run0_r <= wd[`TMR_RUN0];
				run1_r <= wd[`TMR_RUN1];
			end
			if (bus_wr && hit(AVS_ADDRESS_IN, `TMR_IDX_MASK)) begin
				mask_r <= wd[1:0];
			end
		end
	end

	// ----------------------------------------
	// Machine cycle prescaler
	// ----------------------------------------
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			pre_r <= 8'h00;
			tick_r <= 1'b0;
		end else begin
			pre_r <= (pre_r == 8'(DIV - 1)) ? 8'h00 : pre_r + 8'h01;
			tick_r <= (pre_r == 8'(DIV - 1)); // [RL3]
		end
	end

	assign cnt_pin = {COUNT_PIN_ONE_IN, COUNT_PIN_ZERO_IN};
	for (genvar g = 0; g < 2; g++) begin : g_pin
		timer_pin_sampler u_smp (
			.clk_in(CLOCK_IN),
			.rst_in(RST_IN),
			.tick_in(tick_r),
			.pin_in(cnt_pin[g]),
			.fall_out(fall[g])
		);
	end

	// ----------------------------------------
	// Count enables
	// ----------------------------------------
	assign m0 = timer_pkg::tmr_mode_t'(mode_r[`TMR_M0_HI:`TMR_M0_LO]); // [RL9]
	assign m1 = timer_pkg::tmr_mode_t'(mode_r[`TMR_M1_HI:`TMR_M1_LO]); // [RL8]
	assign split0 = (m0 == timer_pkg::MODE_SPLIT);
	assign en0 = run0_r & (~mode_r[`TMR_GATE0] | GATE_PIN_ZERO_IN); // [RL7] [RL11]
	// Split counter 0 takes run bit 1; counter 1 then runs on its gate alone
	assign en1 = (split0 | run1_r) & (~mode_r[`TMR_GATE1] | GATE_PIN_ONE_IN) // [RL6] [RL11]
		& (m1 != timer_pkg::MODE_SPLIT); // [RL8]
	assign inc0 = en0 & (mode_r[`TMR_CT0] ? fall[0] : tick_r); // [RL2] [RL4]
	assign inc1 = en1 & (mode_r[`TMR_CT1] ? fall[1] : tick_r); // [RL2] [RL4]
	assign inc0h = split0 & run1_r & tick_r; // [RL14]
	assign st0 = step(m0, high0_r, low0_r);
	assign st1 = step(m1, high1_r, low1_r);
	assign ovf0 = inc0 & st0[16];
	assign ovf1 = split0 ? (inc0h & (&high0_r)) : (inc1 & st1[16]); // [RL14]

	// ----------------------------------------
	// Count registers
	// ----------------------------------------
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			low0_r <= `TMR_BYTE_RST;
			high0_r <= `TMR_BYTE_RST;
		end else begin
			if (bus_wr && hit(AVS_ADDRESS_IN, `TMR_IDX_LOW0)) begin
				low0_r <= wd; // [RL16]
			end else if (inc0) begin
				low0_r <= st0[7:0]; // [RL1]
			end
			if (bus_wr && hit(AVS_ADDRESS_IN, `TMR_IDX_HIGH0)) begin
				high0_r <= wd; // [RL16]
			end else if (inc0h) begin
				high0_r <= high0_r + 8'h01; // [RL10] [RL14]
			end else if (inc0 && !split0) begin
				high0_r <= st0[15:8];
			end
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			low1_r <= `TMR_BYTE_RST;
			high1_r <= `TMR_BYTE_RST;
		end else begin
			if (bus_wr && hit(AVS_ADDRESS_IN, `TMR_IDX_LOW1)) begin
				low1_r <= wd; // [RL16]
			end else if (inc1) begin
				low1_r <= st1[7:0]; // [RL1]
			end
			if (bus_wr && hit(AVS_ADDRESS_IN, `TMR_IDX_HIGH1)) begin
				high1_r <= wd; // [RL16]
			end else if (inc1) begin
				high1_r <= st1[15:8];
			end
		end
	end

	// ----------------------------------------
	// Overflow flags
	// ----------------------------------------
	// Hardware set beats a software clear in the same cycle
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			flag0_r <= 1'b0;
			flag1_r <= 1'b0;
		end else begin
			if (ovf0) begin
				flag0_r <= 1'b1; // [RL12] [RL13] [RL15]
			end else if (bus_wr && hit(AVS_ADDRESS_IN, `TMR_IDX_CTRL)) begin
				flag0_r <= wd[`TMR_FLAG0];
			end
			if (ovf1) begin
				flag1_r <= 1'b1; // [RL14] [RL15]
			end else if (bus_wr && hit(AVS_ADDRESS_IN, `TMR_IDX_CTRL)) begin
				flag1_r <= wd[`TMR_FLAG1];
			end
		end
	end

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	always_comb begin
		stat_nxt = stat_r;
		if (bus_rd && hit(AVS_ADDRESS_IN, `TMR_IDX_STAT)) begin
			stat_nxt = stat_r & ~AVS_READDATA_OUT[1:0]; // Clear only what was reported, no event lost
		end
		stat_nxt = stat_nxt | {ovf1, ovf0};
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			stat_r <= 2'h0;
			IRQ_OUT <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			IRQ_OUT <= |(stat_r & mask_r);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);

	property p_tick_period;
		(DIV == 6) && tick_r |=> !tick_r [*5] ##1 tick_r;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("tick period wrong"); // [RL3]
	property p_mode0_wrap;
		inc0 && m0 == timer_pkg::MODE_PRESCALE13 && high0_r == 8'hFF && &low0_r[4:0] && !bus_wr
			|=> flag0_r && stat_r[0] && high0_r == 8'h00 && low0_r[4:0] == 5'h00
			&& low0_r[7:5] == $past(low0_r[7:5]);
	endproperty
	a_mode0_wrap: assert property (p_mode0_wrap) else $error("13-bit wrap wrong"); // [RL12]
	property p_reload;
		inc0 && m0 == timer_pkg::MODE_RELOAD8 && low0_r == 8'hFF && !bus_wr
			|=> low0_r == $past(high0_r) && $stable(high0_r) && flag0_r;
	endproperty
	a_reload: assert property (p_reload) else $error("auto-reload wrong"); // [RL13]
	property p_full16;
		inc1 && !split0 && m1 == timer_pkg::MODE_FULL16 && {high1_r, low1_r} == 16'hFFFF && !bus_wr
			|=> {high1_r, low1_r} == 16'h0000 && flag1_r;
	endproperty
	a_full16: assert property (p_full16) else $error("16-bit wrap wrong"); // [RL15]
	property p_halt1;
		m1 == timer_pkg::MODE_SPLIT && !bus_wr |=> $stable({high1_r, low1_r});
	endproperty
	a_halt1: assert property (p_halt1) else $error("counter 1 not halted"); // [RL8]
	property p_gate1;
		mode_r[`TMR_GATE1] && !GATE_PIN_ONE_IN && !bus_wr |=> $stable({high1_r, low1_r});
	endproperty
	a_gate1: assert property (p_gate1) else $error("gate 1 ignored"); // [RL6]
	property p_free0;
		!mode_r[`TMR_GATE0] && run0_r && !mode_r[`TMR_CT0] && tick_r
			&& m0 == timer_pkg::MODE_FULL16 && !bus_wr
			|=> {high0_r, low0_r} == $past({high0_r, low0_r}) + 16'h0001;
	endproperty
	a_free0: assert property (p_free0) else $error("counter 0 did not count"); // [RL7]
	property p_ext0;
		mode_r[`TMR_CT0] && !fall[0] && !split0 && !bus_wr |=> $stable({high0_r, low0_r});
	endproperty
	a_ext0: assert property (p_ext0) else $error("count without pin edge"); // [RL4]
	property p_split_high;
		split0 && run1_r && tick_r && high0_r == 8'hFF && !bus_wr
			|=> flag1_r && high0_r == 8'h00;
	endproperty
	a_split_high: assert property (p_split_high) else $error("split high overflow wrong"); // [RL14]
	property p_wr_low0;
		bus_wr && hit(AVS_ADDRESS_IN, `TMR_IDX_LOW0) |=> low0_r == $past(AVS_WRITEDATA_IN[7:0]);
	endproperty
	a_wr_low0: assert property (p_wr_low0) else $error("low byte write lost"); // [RL16]
	c_reload: cover property (inc0 && m0 == timer_pkg::MODE_RELOAD8 && low0_r == 8'hFF);
	c_split: cover property (split0 && inc0h && high0_r == 8'hFF);
	c_irq: cover property (IRQ_OUT);
endmodule
`default_nettype wire

// ==== rtl/timer_defs.svh ====
// Register indices, field positions, reset values and timing counts
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define TMR_IDX_CTRL 10'h088
`define TMR_IDX_MODE 10'h089
`define TMR_IDX_LOW0 10'h08A
`define TMR_IDX_LOW1 10'h08B
`define TMR_IDX_HIGH0 10'h08C
`define TMR_IDX_HIGH1 10'h08D
`define TMR_IDX_STAT 10'h090
`define TMR_IDX_MASK 10'h091

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define TMR_GATE1 7
`define TMR_CT1 6
`define TMR_M1_HI 5
`define TMR_M1_LO 4
`define TMR_GATE0 3
`define TMR_CT0 2
`define TMR_M0_HI 1
`define TMR_M0_LO 0

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TMR_FLAG1 7
`define TMR_RUN1 6
`define TMR_FLAG0 5
`define TMR_RUN0 4

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define TMR_MODE_RST 8'h00
`define TMR_BYTE_RST 8'h00
`define TMR_PERIPH_DIV 6

`endif

// ==== rtl/timer_pkg.sv ====
// Types shared by the timer/counter files
package timer_pkg;
	typedef enum logic [1:0] {
		MODE_PRESCALE13,
		MODE_FULL16,
		MODE_RELOAD8,
		MODE_SPLIT
	} tmr_mode_t;
endpackage

// ==== rtl/timer_pin_sampler.sv ====
// Count pin sampler: one sample per machine cycle, falling edge pulse
`timescale 1ns/1ps
`default_nettype none
module timer_pin_sampler (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic tick_in,
	input wire logic pin_in,
	output var logic fall_out
);
	logic samp_r;

	// ----------------------------------------
	// Sampling
	// ----------------------------------------
	// Reset low so a pin held low at start gives no false edge
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			samp_r <= 1'b0;
			fall_out <= 1'b0;
		end else begin
			if (tick_in) begin
				samp_r <= pin_in;
			end
			fall_out <= tick_in & samp_r & ~pin_in; // [RL5]
		end
	end
endmodule
`default_nettype wire

// ==== verification/timer_pin_driver.sv ====
// Far-side model: external count and gate pins
`timescale 1ns/1ps
`default_nettype none
module timer_pin_driver (
	input wire logic clk_in,
	output var logic count_zero_out,
	output var logic count_one_out,
	output var logic gate_zero_out,
	output var logic gate_one_out
);
	// ----------------------------------------
	// Pin activity
	// ----------------------------------------
	initial begin
		count_zero_out = 1'b1;
		count_one_out = 1'b1;
		gate_zero_out = 1'b1;
		gate_one_out = 1'b1;
	end
	// Each level held hold_cyc clocks, never under 6, so no edge is lost
	task automatic pulse(input int sel, input int n, input int hold_cyc);
		for (int i = 0; i < 2 * n; i++) begin
			if (sel == 0) begin
				count_zero_out <= i[0];
			end else begin
				count_one_out <= i[0];
			end
			repeat (hold_cyc) @(posedge clk_in);
		end
	endtask
	task automatic set_gates(input logic g0, input logic g1);
		gate_zero_out <= g0;
		gate_one_out <= g1;
		@(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// ==== verification/dual_timer_counter_mode_ctrl_tb.sv ====
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
`define CHECK_EQ(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
	$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module dual_timer_counter_mode_ctrl_tb;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic [11:0] avs_address = 12'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq, cz, co, gz, go;
	logic [31:0] q1, q2;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	// ----------------------------------------
	// Design and pins
	// ----------------------------------------
	always #10 clock_in = ~clock_in;
	dual_timer_counter_mode_ctrl dut (.CLOCK_IN(clock_in), .RST_IN(rst_in), .AVS_ADDRESS_IN(avs_address),
		.AVS_READ_IN(avs_read), .AVS_WRITE_IN(avs_write), .AVS_WRITEDATA_IN(avs_writedata),
		.AVS_BYTEENABLE_IN(avs_byteenable), .AVS_READDATA_OUT(avs_readdata),
		.AVS_WAITREQUEST_OUT(avs_waitrequest), .COUNT_PIN_ZERO_IN(cz), .COUNT_PIN_ONE_IN(co),
		.GATE_PIN_ZERO_IN(gz), .GATE_PIN_ONE_IN(go), .IRQ_OUT(irq));
	timer_pin_driver pins (.clk_in(clock_in), .count_zero_out(cz), .count_one_out(co),
		.gate_zero_out(gz), .gate_one_out(go));
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	// Extra edge at the end so the next request never lands in the release step
	task automatic bus(input logic wr_en, input logic [9:0] idx, input logic [31:0] d, output logic [31:0] q);
		avs_address <= {idx, 2'b00};
		avs_write <= wr_en;
		avs_read <= !wr_en;
		avs_writedata <= d;
		@(posedge clock_in);
		while (avs_waitrequest !== 1'b0) @(posedge clock_in);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clock_in);
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, idx, {24'h00_0000, d}, q);
	endtask
	task automatic rd(input logic [9:0] idx, output logic [31:0] q);
		bus(1'b0, idx, 32'h0000_0000, q);
	endtask
	task automatic give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		rd(`TMR_IDX_MODE, q1);
		`CHECK_EQ(q1, 32'h0000_0000)
		wr(`TMR_IDX_MODE, 8'hA5);
		avs_byteenable <= 4'h0;
		wr(`TMR_IDX_MODE, 8'h11);
		avs_byteenable <= 4'hF;
		rd(`TMR_IDX_MODE, q1);
		`CHECK_EQ(q1, 32'h0000_00A5)
		rd(10'h0FF, q1);
		`CHECK_EQ(q1, 32'h0000_0000)
		wr(`TMR_IDX_LOW1, 8'h3C);
		rd(`TMR_IDX_LOW1, q1);
		`CHECK_EQ(q1, 32'h0000_003C)
		$display("test regs done");
	endtask
	task automatic t_rate();
		wr(`TMR_IDX_MODE, 8'h11);
		wr(`TMR_IDX_LOW0, 8'h00);
		wr(`TMR_IDX_CTRL, 8'h10);
		rd(`TMR_IDX_LOW0, q1);
		repeat (57) @(posedge clock_in);
		rd(`TMR_IDX_LOW0, q2);
		`CHECK_EQ(q2 - q1, 32'h0000_000A)
		wr(`TMR_IDX_CTRL, 8'h00);
		$display("test rate done");
	endtask
	task automatic t_wrap16();
		wr(`TMR_IDX_HIGH0, 8'hFF);
		wr(`TMR_IDX_LOW0, 8'hFE);
		wr(`TMR_IDX_HIGH1, 8'hFF);
		wr(`TMR_IDX_LOW1, 8'hFE);
		wr(`TMR_IDX_CTRL, 8'h50);
		repeat (30) @(posedge clock_in);
		rd(`TMR_IDX_CTRL, q1);
		`CHECK_EQ(q1, 32'h0000_00F0)
		rd(`TMR_IDX_HIGH0, q1);
		`CHECK_EQ(q1, 32'h0000_0000)
		rd(`TMR_IDX_HIGH1, q1);
		`CHECK_EQ(q1, 32'h0000_0000)
		`CHECK_EQ(irq, 1'b0)
		rd(`TMR_IDX_STAT, q1);
		`CHECK_EQ(q1, 32'h0000_0003)
		rd(`TMR_IDX_STAT, q1);
		`CHECK_EQ(q1, 32'h0000_0000)
		wr(`TMR_IDX_CTRL, 8'h00);
		$display("test wrap16 done");
	endtask
	task automatic t_mode0();
		wr(`TMR_IDX_MASK, 8'h02);
		wr(`TMR_IDX_MODE, 8'h00);
		wr(`TMR_IDX_HIGH1, 8'hFF);
		wr(`TMR_IDX_LOW1, 8'hFF);
		wr(`TMR_IDX_HIGH0, 8'hFF);
		wr(`TMR_IDX_LOW0, 8'hFF);
		wr(`TMR_IDX_CTRL, 8'h50);
		repeat (12) @(posedge clock_in);
		rd(`TMR_IDX_CTRL, q1);
		`CHECK_EQ(q1, 32'h0000_00F0)
		rd(`TMR_IDX_HIGH1, q1);
		`CHECK_EQ(q1, 32'h0000_0000)
		rd(`TMR_IDX_LOW1, q1);
		`CHECK_EQ(q1[7:5], 3'b111)
		rd(`TMR_IDX_HIGH0, q1);
		`CHECK_EQ(q1, 32'h0000_0000)
		rd(`TMR_IDX_LOW0, q1);
		`CHECK_EQ(q1[7:5], 3'b111)
		`CHECK_EQ(irq, 1'b1)
		rd(`TMR_IDX_STAT, q1);
		`CHECK_EQ(q1, 32'h0000_0003)
		repeat (2) @(posedge clock_in);
		`CHECK_EQ(irq, 1'b0)
		wr(`TMR_IDX_CTRL, 8'h00);
		$display("test mode0 done");
	endtask
	task automatic t_reload();
		wr(`TMR_IDX_MODE, 8'h02);
		wr(`TMR_IDX_HIGH0, 8'hF0);
		wr(`TMR_IDX_LOW0, 8'hFE);
		wr(`TMR_IDX_CTRL, 8'h10);
		repeat (24) @(posedge clock_in);
		rd(`TMR_IDX_CTRL, q1);
		`CHECK_EQ(q1, 32'h0000_0030)
		rd(`TMR_IDX_HIGH0, q1);
		`CHECK_EQ(q1, 32'h0000_00F0)
		rd(`TMR_IDX_LOW0, q1);
		`CHECK_EQ(q1[7:4], 4'hF)
		wr(`TMR_IDX_CTRL, 8'h00);
		$display("test reload done");
	endtask
	task automatic t_halt_split();
		wr(`TMR_IDX_MODE, 8'h30);
		wr(`TMR_IDX_LOW1, 8'h10);
		wr(`TMR_IDX_CTRL, 8'h40);
		repeat (30) @(posedge clock_in);
		rd(`TMR_IDX_LOW1, q1);
		`CHECK_EQ(q1, 32'h0000_0010)
		wr(`TMR_IDX_MODE, 8'h03);
		wr(`TMR_IDX_LOW0, 8'h00);
		rd(`TMR_IDX_HIGH0, q1);
		repeat (57) @(posedge clock_in);
		rd(`TMR_IDX_HIGH0, q2);
		`CHECK_EQ(q2 - q1, 32'h0000_000A)
		rd(`TMR_IDX_LOW0, q1);
		`CHECK_EQ(q1, 32'h0000_0000)
		wr(`TMR_IDX_HIGH0, 8'hFF);
		repeat (8) @(posedge clock_in);
		rd(`TMR_IDX_CTRL, q1);
		`CHECK_EQ(q1, 32'h0000_00C0)
		wr(`TMR_IDX_CTRL, 8'h00);
		$display("test halt split done");
	endtask
	task automatic t_pins();
		wr(`TMR_IDX_MODE, 8'h5D);
		wr(`TMR_IDX_LOW0, 8'h00);
		wr(`TMR_IDX_LOW1, 8'h00);
		wr(`TMR_IDX_CTRL, 8'h50);
		pins.set_gates(1'b0, 1'b1);
		pins.pulse(1, 3, 6);
		pins.pulse(0, 2, 13);
		rd(`TMR_IDX_LOW1, q1);
		`CHECK_EQ(q1, 32'h0000_0003)
		rd(`TMR_IDX_LOW0, q1);
		`CHECK_EQ(q1, 32'h0000_0000)
		pins.set_gates(1'b1, 1'b0);
		pins.pulse(0, 2, 13);
		wr(`TMR_IDX_MODE, 8'hDD);
		pins.pulse(1, 2, 6);
		rd(`TMR_IDX_LOW0, q1);
		`CHECK_EQ(q1, 32'h0000_0002)
		rd(`TMR_IDX_LOW1, q1);
		`CHECK_EQ(q1, 32'h0000_0003)
		wr(`TMR_IDX_MODE, 8'h05);
		pins.set_gates(1'b0, 1'b0);
		pins.pulse(0, 2, 13);
		rd(`TMR_IDX_LOW0, q1);
		`CHECK_EQ(q1, 32'h0000_0004)
		$display("test pins done");
	endtask
	// ----------------------------------------
	// Main sequence and timeout
	// ----------------------------------------
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 10000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		repeat (3) @(posedge clock_in);
		rst_in <= 1'b0;
		@(posedge clock_in);
		t_regs();
		t_rate();
		t_wrap16();
		t_mode0();
		t_reload();
		t_halt_split();
		t_pins();
		give_verdict();
	end
endmodule
`default_nettype wire
